// *** bench/prc_peri_model.sv ***
// Purpose: behavioural peripherals that answer reset requests with done
// Assumes: done is a level on the system clock
// Notes:   slow selects a long completion time
`timescale 1ns/1ns
`default_nettype none
module prc_peri_model (
    input  wire logic              clk,   // system clock
    input  wire logic              rstn,  // async reset, active low
    input  wire logic              slow,  // long completion when high
    input  wire prc_pkg::prc_rst_t rst,   // reset requests
    output var  prc_pkg::prc_rst_t done   // completion per peripheral
);
    import prc_pkg::*;
    logic [5:0] cnt_ff [PRC_NUM_CH];
    always_ff @(posedge clk or negedge rstn) begin
        for (int i = 0; i < PRC_NUM_CH; i++) begin
            if (!rstn || !rst[i]) begin
                cnt_ff[i] <= 6'h00;
            end else if (cnt_ff[i] != 6'h3F) begin
                cnt_ff[i] <= cnt_ff[i] + 6'h01;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < PRC_NUM_CH; i++) begin
            done[i] = rst[i] && (cnt_ff[i] >= (slow ? 6'h1E : 6'h01));
        end
    end
endmodule
`default_nettype wire

// *** bench/tb_prc_top.sv ***
// Purpose: self-checking bench for the peripheral reset controller
// Assumes: model peripherals finish after 1 or 30 cycles
// Notes:   random masks and lanes from an lfsr
`timescale 1ns/1ns
`default_nettype none
module tb_prc_top;
    import prc_pkg::*;
    logic        clk, rstn, cyc, stb, we, slow, ack;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dwr, drd, q, lf, m1, m2, e1;
    prc_rst_t    done, rst;
    int          mismatches, num_checks, cyc_cnt;
    prc_top dut (.clk(clk), .rstn(rstn), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
        .wb_adr(adr), .wb_sel(sel), .wb_dat_wr(dwr), .wb_dat_rd(drd), .wb_ack(ack),
        .peri_done(done), .peri_rst(rst));
    prc_peri_model peri (.clk(clk), .rstn(rstn), .slow(slow), .rst(rst), .done(done));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] lanes(input logic [31:0] d, input logic [3:0] s);
        return d & {13'h0, {3{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= s;
        dwr <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        q = drd;
        cyc <= 1'b0;
        stb <= 1'b0;
        check("ack wait", n, 32'h2);
        #1;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (rst !== '0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        #1;
        check("idle", rst, 32'h0);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        {rstn, cyc, stb, we, slow, adr, sel, dwr} <= '0;
        lf = 32'h0001_617B;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, PRC_RST0_ADR, 32'h0, 4'hF);
        check("reset value", q, 32'h0);
        for (int i = 0; i < PRC_NUM_CH; i++) begin
            bus(1'b1, PRC_RST0_ADR, 32'h1 << i, 4'hF);
            check("bit map", rst, 32'h1 << i);
            if (i == 18) check("crypto", rst.crypto_group_reset, 32'h1);
            if (i == 0) check("dma", rst.dma_std_reset, 32'h1);
            if (i == 1) check("watchdog", rst.watchdog_a_reset, 32'h1);
            if (i == 5) check("counter a", rst.counter_unit_a_reset, 32'h1);
            if (i == 10) check("counter f", rst.counter_unit_f_reset, 32'h1);
            repeat (4) @(posedge clk);
            #1;
            check("held", rst, 32'h1 << i);
            wait_idle();
        end
        bus(1'b1, PRC_RST0_ADR, 32'h0, 4'hF);
        check("write zero", rst, 32'h0);
        bus(1'b1, 8'h08, 32'hFFFF_FFFF, 4'hF);
        check("unmapped write", rst, 32'h0);
        bus(1'b0, 8'h08, 32'h0, 4'hF);
        check("unmapped read", q, 32'h0);
        slow <= 1'b1;
        bus(1'b1, PRC_RST0_ADR, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, PRC_RST0_ADR, 32'h0, 4'hF);
        check("busy read", q, 32'h0007_FFFF);
        wait_idle();
        bus(1'b0, PRC_RST0_ADR, 32'h0, 4'hF);
        check("done read", q, 32'h0);
        repeat (20) begin
            lf = lfsr(lf);
            m1 = lf;
            slow <= lf[31];
            lf = lfsr(lf);
            m2 = lf;
            e1 = lanes(m1, m2[3:0]);
            bus(1'b1, PRC_RST0_ADR, m1, m2[3:0]);
            check("random set", rst, e1);
            bus(1'b1, PRC_RST0_ADR, m2, 4'hF);
            check("second set", rst, e1 | lanes(m2, 4'hF));
            bus(1'b0, PRC_RST0_ADR, 32'h0, 4'hF);
            if (slow) check("random read", q, e1 | lanes(m2, 4'hF));
            wait_idle();
        end
        final_report();
    end
endmodule
`default_nettype wire

// *** rtl/prc_channel.sv ***
// Purpose: one peripheral reset channel, request to completion
// Assumes: done feedback comes from logic on the same clock
// Notes:   reset held at least the minimum pulse, then until done is high
`timescale 1ns/1ns
`default_nettype none
module prc_channel (
    input  wire logic clk,     // system clock
    input  wire logic rstn,    // async reset, active low
    input  wire logic start,   // one-cycle request from register write
    input  wire logic done,    // peripheral reports its reset finished
    output var  logic rst_ff   // reset to peripheral, also busy readback
);
    import prc_pkg::*;

    prc_state_t             state_ff;
    prc_state_t             nxt_state;
    logic [PRC_CNT_W-1:0]   cnt_ff;
    logic [PRC_CNT_W-1:0]   nxt_cnt;
    logic                   nxt_rst;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            PRC_ST_IDLE: begin
                if (start) begin
                    nxt_state = PRC_ST_RESET;
                    nxt_cnt   = PRC_CNT_LOAD;
                end
            end
            PRC_ST_RESET: begin
                if (cnt_ff != PRC_CNT_ZERO) begin
                    nxt_cnt = cnt_ff - 4'h1;
                end else if (done) begin
                    nxt_state = PRC_ST_IDLE;
                end
            end
        endcase
        nxt_rst = (nxt_state == PRC_ST_RESET);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= PRC_ST_IDLE;
            cnt_ff   <= PRC_CNT_ZERO;
            rst_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            rst_ff   <= nxt_rst;
        end
    end

    property p_start_asserts;
        @(posedge clk) disable iff (!rstn)
        (!rst_ff && start) |=> rst_ff;
    endproperty
    a_start_asserts: assert property (p_start_asserts) else $error("reset not asserted");

    property p_min_pulse;
        @(posedge clk) disable iff (!rstn)
        $rose(rst_ff) |-> rst_ff [*5];
    endproperty
    a_min_pulse: assert property (p_min_pulse) else $error("reset pulse too short");

    property p_clear_on_done;
        @(posedge clk) disable iff (!rstn)
        (rst_ff && cnt_ff == PRC_CNT_ZERO && done) |=> !rst_ff;
    endproperty
    a_clear_on_done: assert property (p_clear_on_done) else $error("reset not released");

    property p_hold_without_done;
        @(posedge clk) disable iff (!rstn)
        (rst_ff && !done) |=> rst_ff;
    endproperty
    a_hold_without_done: assert property (p_hold_without_done) else $error("early release");
endmodule
`default_nettype wire

// *** rtl/prc_pkg.sv ***
// Purpose: shared constants and types for the peripheral reset controller
// Assumes: 125 MHz system clock, 32-bit classic Wishbone register access
// Notes:   reset request struct packs with field order equal to register bit order
package prc_pkg;

    localparam int          PRC_ADR_W      = 8;
    localparam int          PRC_DAT_W      = 32;
    localparam int          PRC_SEL_W      = 4;
    localparam int          PRC_NUM_CH     = 19;
    localparam logic [7:0]  PRC_RST0_ADR   = 8'h04;
    localparam logic [18:0] PRC_RST0_RESET = 19'h0_0000;

    // register bit positions
    localparam int PRC_BIT_DMA     = 0;
    localparam int PRC_BIT_WDT_A   = 1;
    localparam int PRC_BIT_CNT_A   = 5;
    localparam int PRC_NUM_CNT     = 6;
    localparam int PRC_BIT_CRYPTO  = 18;

    // least width of the reset pulse, then cycles at the system clock rate
    localparam int         PRC_CLK_PERIOD_NS = 8;
    localparam int         PRC_RST_MIN_NS    = 40;
    localparam int         PRC_RST_MIN_CYC   =
        (PRC_RST_MIN_NS + PRC_CLK_PERIOD_NS - 1) / PRC_CLK_PERIOD_NS;
    localparam int         PRC_CNT_W         = 4;
    localparam logic [3:0] PRC_CNT_LOAD      = 4'(PRC_RST_MIN_CYC - 1);
    localparam logic [3:0] PRC_CNT_ZERO      = 4'h0;

    typedef enum logic {
        PRC_ST_IDLE  = 1'b0,
        PRC_ST_RESET = 1'b1
    } prc_state_t;

    typedef struct packed {
        logic crypto_group_reset;          // bit 18
        logic real_time_clock_reset;       // bit 17
        logic two_wire_port_a_reset;       // bit 16
        logic serial_periph_port_c_reset;  // bit 15
        logic serial_periph_port_b_reset;  // bit 14
        logic serial_periph_port_a_reset;  // bit 13
        logic async_serial_b_reset;        // bit 12
        logic async_serial_a_reset;        // bit 11
        logic counter_unit_f_reset;        // bit 10
        logic counter_unit_e_reset;        // bit 9
        logic counter_unit_d_reset;        // bit 8
        logic counter_unit_c_reset;        // bit 7
        logic counter_unit_b_reset;        // bit 6
        logic counter_unit_a_reset;        // bit 5
        logic io_port_c_reset;             // bit 4
        logic io_port_b_reset;             // bit 3
        logic io_port_a_reset;             // bit 2
        logic watchdog_a_reset;            // bit 1
        logic dma_std_reset;               // bit 0
    } prc_rst_t;

endpackage

// *** rtl/prc_top.sv ***
// Purpose: software peripheral reset control, low field group of reset register 0
// Assumes: classic Wishbone slave, 32-bit data, one wait state per access
// Notes:   field reads 1 while its peripheral reset is in progress
// Summary of operation
// - writing 1 starts that peripheral's reset
// - field reads 1 while reset in progress
// - field reads 0 when done or idle
// - bit 18 resets all crypto engines together
// - bit 0 resets standard DMA engine
// - bit 1 resets first watchdog timer
// - timer n reset on bit 5 plus n
`timescale 1ns/1ns
`default_nettype none
module prc_top (
    input  wire logic                          clk,       // system clock
    input  wire logic                          rstn,      // async reset, active low
    input  wire logic                          wb_cyc,    // bus cycle
    input  wire logic                          wb_stb,    // strobe
    input  wire logic                          wb_we,     // write enable
    input  wire logic [prc_pkg::PRC_ADR_W-1:0] wb_adr,    // byte address
    input  wire logic [prc_pkg::PRC_SEL_W-1:0] wb_sel,    // byte enables
    input  wire logic [prc_pkg::PRC_DAT_W-1:0] wb_dat_wr, // write data
    output var  logic [prc_pkg::PRC_DAT_W-1:0] wb_dat_rd, // read data
    output var  logic                          wb_ack,    // acknowledge
    input  wire prc_pkg::prc_rst_t             peri_done, // per-peripheral done
    output var  prc_pkg::prc_rst_t             peri_rst   // per-peripheral reset
);
    import prc_pkg::*;

    logic [PRC_NUM_CH-1:0] rst_vec;
    logic [PRC_NUM_CH-1:0] done_vec;
    logic [PRC_NUM_CH-1:0] start_vec;
    logic [PRC_DAT_W-1:0]  wr_bits;
    logic                  wr_hit;
    logic                  nxt_ack;
    logic [PRC_DAT_W-1:0]  nxt_dat;
    prc_rst_t              wr_fields;

    function automatic logic reg_hit(input logic [PRC_ADR_W-1:0] adr);
        reg_hit = (adr == PRC_RST0_ADR);
    endfunction

    function automatic logic [PRC_DAT_W-1:0] sel_mask(input logic [PRC_SEL_W-1:0] sel);
        logic [PRC_DAT_W-1:0] m;
        m = '0;
        for (int i = 0; i < PRC_SEL_W; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        sel_mask = m;
    endfunction

    assign done_vec = PRC_NUM_CH'(peri_done);
    assign wr_fields = prc_rst_t'(wr_bits[PRC_NUM_CH-1:0]);

    // write takes effect at the edge where the master sees ack
    always_comb begin
        wr_hit    = wb_cyc && wb_stb && wb_we && wb_ack && reg_hit(wb_adr);
        wr_bits   = wb_dat_wr & sel_mask(wb_sel);
        start_vec = wr_hit ? wr_bits[PRC_NUM_CH-1:0] : '0;
    end

    always_comb begin
        nxt_ack = wb_cyc && wb_stb && !wb_ack;
        nxt_dat = wb_dat_rd;
        if (nxt_ack) begin
            nxt_dat = '0;
            if (reg_hit(wb_adr)) begin
                nxt_dat[PRC_NUM_CH-1:0] = rst_vec;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack    <= 1'b0;
            wb_dat_rd <= '0;
        end else begin
            wb_ack    <= nxt_ack;
            wb_dat_rd <= nxt_dat;
        end
    end

    // one sequencer per field; bit 18 drives all three crypto engines
    for (genvar g = 0; g < PRC_NUM_CH; g++) begin : g_ch
        prc_channel u_ch (
            .clk    (clk),
            .rstn   (rstn),
            .start  (start_vec[g]),
            .done   (done_vec[g]),
            .rst_ff (rst_vec[g])
        );
    end

    assign peri_rst = prc_rst_t'(rst_vec);

    property p_read_state;
        @(posedge clk) disable iff (!rstn)
        (wb_cyc && wb_stb && !wb_ack && !wb_we && reg_hit(wb_adr))
            |=> (wb_ack && wb_dat_rd[PRC_NUM_CH-1:0] == $past(rst_vec));
    endproperty
    a_read_state: assert property (p_read_state) else $error("readback mismatch");

    property p_crypto_group;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && wr_bits[PRC_BIT_CRYPTO] && !peri_rst.crypto_group_reset)
            |=> peri_rst.crypto_group_reset;
    endproperty
    a_crypto_group: assert property (p_crypto_group) else $error("crypto reset missing");

    property p_dma;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && wr_bits[PRC_BIT_DMA] && !peri_rst.dma_std_reset)
            |=> peri_rst.dma_std_reset;
    endproperty
    a_dma: assert property (p_dma) else $error("dma reset missing");

    property p_wdt;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && wr_bits[PRC_BIT_WDT_A] && !peri_rst.watchdog_a_reset)
            |=> peri_rst.watchdog_a_reset;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset missing");

    property p_counter_a;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && wr_bits[PRC_BIT_CNT_A] && !peri_rst.counter_unit_a_reset)
            |=> peri_rst.counter_unit_a_reset;
    endproperty
    a_counter_a: assert property (p_counter_a) else $error("timer reset missing");

    property p_write_zero;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && wr_bits[PRC_NUM_CH-1:0] == PRC_RST0_RESET && rst_vec == PRC_RST0_RESET)
            |=> (rst_vec == PRC_RST0_RESET);
    endproperty
    a_write_zero: assert property (p_write_zero) else $error("write of 0 acted");

    property p_idle_reads_zero;
        @(posedge clk) disable iff (!rstn)
        (wb_ack && !wb_we && reg_hit(wb_adr) && $past(rst_vec) == PRC_RST0_RESET)
            |-> (wb_dat_rd == '0);
    endproperty
    a_idle_reads_zero: assert property (p_idle_reads_zero) else $error("idle reads nonzero");

    property p_ack_follows_req;
        @(posedge clk) disable iff (!rstn)
        (wb_cyc && wb_stb && !wb_ack) |=> wb_ack;
    endproperty
    a_ack_follows_req: assert property (p_ack_follows_req) else $error("ack missing");

    property p_ack_single;
        @(posedge clk) disable iff (!rstn)
        wb_ack |=> !wb_ack;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack too long");

    property p_no_ack_idle;
        @(posedge clk) disable iff (!rstn)
        !(wb_cyc && wb_stb) |=> !wb_ack;
    endproperty
    a_no_ack_idle: assert property (p_no_ack_idle) else $error("ack without request");

    property p_upper_zero;
        @(posedge clk) disable iff (!rstn)
        wb_ack |-> (wb_dat_rd[PRC_DAT_W-1:PRC_NUM_CH] == '0);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits nonzero");

    property p_unmapped_read;
        @(posedge clk) disable iff (!rstn)
        (wb_cyc && wb_stb && !wb_ack && !reg_hit(wb_adr)) |=> (wb_dat_rd == '0);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");

    property p_unmapped_write;
        @(posedge clk) disable iff (!rstn)
        (wb_cyc && wb_stb && wb_ack && !reg_hit(wb_adr) && rst_vec == PRC_RST0_RESET)
            |=> (rst_vec == PRC_RST0_RESET);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write acted");

    property p_no_spurious;
        @(posedge clk) disable iff (!rstn)
        (!wr_hit && rst_vec == PRC_RST0_RESET) |=> (rst_vec == PRC_RST0_RESET);
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("reset without write");

    property p_counter_f;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && wr_bits[PRC_BIT_CNT_A+PRC_NUM_CNT-1] && !peri_rst.counter_unit_f_reset)
            |=> peri_rst.counter_unit_f_reset;
    endproperty
    a_counter_f: assert property (p_counter_f) else $error("last timer reset missing");

    property p_io_port_a;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && wr_fields.io_port_a_reset && !peri_rst.io_port_a_reset)
            |=> peri_rst.io_port_a_reset;
    endproperty
    a_io_port_a: assert property (p_io_port_a) else $error("io port reset missing");

    property p_async_serial_a;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && wr_fields.async_serial_a_reset && !peri_rst.async_serial_a_reset)
            |=> peri_rst.async_serial_a_reset;
    endproperty
    a_async_serial_a: assert property (p_async_serial_a) else $error("serial reset missing");

    property p_serial_periph_c;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && wr_fields.serial_periph_port_c_reset && !peri_rst.serial_periph_port_c_reset)
            |=> peri_rst.serial_periph_port_c_reset;
    endproperty
    a_serial_periph_c: assert property (p_serial_periph_c) else $error("periph reset missing");

    property p_two_wire;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && wr_fields.two_wire_port_a_reset && !peri_rst.two_wire_port_a_reset)
            |=> peri_rst.two_wire_port_a_reset;
    endproperty
    a_two_wire: assert property (p_two_wire) else $error("two wire reset missing");

    property p_rtc;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && wr_fields.real_time_clock_reset && !peri_rst.real_time_clock_reset)
            |=> peri_rst.real_time_clock_reset;
    endproperty
    a_rtc: assert property (p_rtc) else $error("clock unit reset missing");
endmodule
`default_nettype wire
